/* design/pas_pkg.sv */
// constants and types shared by the auto-shutdown control block
// ****************************************************************
// How it works
// - A selected source going active sets the shutdown flag, and while it is set the outputs sit in their shutdown state.
// - A source select of zero turns auto-shutdown off so only a software write can set the flag.
// - Select 001 trips on comparator one high, 010 on comparator two high, 011 on either.
// - Select 100 trips while the interrupt pin is low.
// - Select 101, 110 and 111 trip on a low interrupt pin or comparator one, two or either high.
// - In shutdown pair A/C is driven low for 00, high for 01 and released for 1x.
// - In shutdown pair B/D is driven low for 00, high for 01 and released for 1x.
// - With auto restart on the flag clears itself once the source is gone, otherwise only software clears it.
// ****************************************************************
package pas_pkg;

   // ****************************************************************
   // register map, byte addresses
   // ****************************************************************
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_CFG = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam logic [3:0] OFF_MASK = 4'hc;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam int CFG_RESTART_BIT = 0;
   localparam int CFG_SYNC_BIT = 1;

   // interrupt status: shutdown entered, automatic restart done
   localparam int IRQ_W = 2;
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_RESTART_BIT = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // ****************************************************************
   // source select codes and pin states
   // ****************************************************************
   localparam logic [2:0] SRC_OFF = 3'h0;
   localparam logic [2:0] SRC_CMP_ONE = 3'h1;
   localparam logic [2:0] SRC_CMP_TWO = 3'h2;
   localparam logic [2:0] SRC_CMP_ANY = 3'h3;
   localparam logic [2:0] SRC_INT = 3'h4;
   localparam logic [2:0] SRC_INT_ANY = 3'h7;
   localparam int SRC_ONE_BIT = 0;
   localparam int SRC_TWO_BIT = 1;
   localparam int SRC_INT_BIT = 2;

   localparam logic [1:0] PS_LOW = 2'h0;
   localparam logic [1:0] PS_HIGH = 2'h1;
   localparam int PS_TRI_BIT = 1;

   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_C = 2;
   localparam int PIN_D = 3;
   localparam int PIN_N = 4;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic shutdown_event_flag;
      logic [2:0] shutdown_source_select;
      logic [1:0] pair_ac_shutdown_state;
      logic [1:0] pair_bd_shutdown_state;
   } pas_ctrl_s;

endpackage

/* design/pas_source_sel.sv */
// shutdown source selection from comparators and interrupt pin
`timescale 1ns/100ps
module pas_source_sel
(
   input wire logic [2:0] shutdown_source_select,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic int_pin,
   output logic trip
);

   // ****************************************************************
   // each select bit enables one source, so codes combine by or
   // ****************************************************************
   wire int_hit;
   wire one_hit;
   wire two_hit;

   // pin counts as active at a low level
   assign int_hit = shutdown_source_select[pas_pkg::SRC_INT_BIT]
      & ~int_pin;
   assign one_hit = shutdown_source_select[pas_pkg::SRC_ONE_BIT]
      & comparator_one;
   assign two_hit = shutdown_source_select[pas_pkg::SRC_TWO_BIT]
      & comparator_two;
   // code zero leaves every term low
   assign trip = int_hit | one_hit | two_hit;

endmodule

/* design/pas_shutdown_ctrl.sv */
// auto-shutdown control with avalon register slave and pin forcing
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pas_shutdown_ctrl
#(
   parameter bit HAS_CMP_TWO = 1'b1
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   input wire logic comparator_one,
   input wire logic comparator_two,
   input wire logic int_pin,
   input wire logic timer_one_tick,
   input wire logic [3:0] pwm_in,
   output logic [3:0] pwm_out,
   output logic [3:0] pwm_oe_n
);

   // ****************************************************************
   // register bus slave
   // ****************************************************************
   logic ack_r;
   logic [31:0] readdata_r;
   pas_pkg::pas_ctrl_s ctrl_r;
   pas_pkg::pas_ctrl_s ctrl_nxt;
   logic [1:0] cfg_r;
   logic [pas_pkg::IRQ_W-1:0] stat_r;
   logic [pas_pkg::IRQ_W-1:0] stat_nxt;
   logic [pas_pkg::IRQ_W-1:0] mask_r;

   wire req;
   wire take;
   wire lane0_wr;
   wire hit_ctrl;
   wire hit_cfg;
   wire hit_stat;
   wire hit_mask;
   wire wr_ctrl;
   wire wr_cfg;
   wire wr_stat;
   wire wr_mask;
   wire [31:0] rd_mux;

   // one wait cycle: request seen, data latched, then released
   assign req = read | write;
   assign waitrequest = req & ~ack_r;
   assign take = req & ~ack_r;
   // writes land in the cycle waitrequest is low, when the master completes
   assign lane0_wr = write & ack_r & byteenable[0];

   // address decode
   assign hit_ctrl = address == pas_pkg::OFF_CTRL;
   assign hit_cfg = address == pas_pkg::OFF_CFG;
   assign hit_stat = address == pas_pkg::OFF_STAT;
   assign hit_mask = address == pas_pkg::OFF_MASK;
   assign wr_ctrl = lane0_wr & hit_ctrl;
   assign wr_cfg = lane0_wr & hit_cfg;
   assign wr_stat = lane0_wr & hit_stat;
   assign wr_mask = lane0_wr & hit_mask;

   // unmapped addresses read as zero, narrow fields in the low bits
   assign rd_mux = hit_ctrl ? {24'h0, ctrl_r} :
      hit_cfg ? {30'h0, cfg_r} :
      hit_stat ? {30'h0, stat_r} :
      hit_mask ? {30'h0, mask_r} : 32'h0;
   assign readdata = readdata_r;

   // handshake and read data capture
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ack_r <= 1'b0;
         readdata_r <= 32'h0;
      end
      else
      begin
         ack_r <= take;
         if (read & take)
            readdata_r <= rd_mux;
      end
   end

   // ****************************************************************
   // comparator sync and source selection
   // ****************************************************************
   logic [1:0] cmp_hold_r;
   wire cmp_two_in;
   wire sync_en;
   wire restart_en;
   wire cmp_one_eff;
   wire cmp_two_eff;
   wire trip;

   // second comparator absent on the small part
   assign cmp_two_in = comparator_two & HAS_CMP_TWO;
   assign sync_en = cfg_r[pas_pkg::CFG_SYNC_BIT];
   assign restart_en = cfg_r[pas_pkg::CFG_RESTART_BIT];
   // synced levels only move at a timer tick, which delays the trip
   assign cmp_one_eff = sync_en ? cmp_hold_r[0] : comparator_one;
   assign cmp_two_eff = sync_en ? cmp_hold_r[1] : cmp_two_in;

   // resample comparators on timer one tick
   always_ff @(posedge core_clk)
   begin
      if (rst)
         cmp_hold_r <= 2'h0;
      else if (timer_one_tick)
         cmp_hold_r <= {cmp_two_in, comparator_one};
   end

   pas_source_sel u_sel
   (
      .shutdown_source_select(ctrl_r.shutdown_source_select),
      .comparator_one(cmp_one_eff),
      .comparator_two(cmp_two_eff),
      .int_pin(int_pin),
      .trip(trip)
   );

   // ****************************************************************
   // shutdown flag and control register
   // ****************************************************************
   wire flag_sw;
   wire flag_auto_clr;
   wire flag_nxt;

   // software write of the flag; a trip in the same cycle still wins
   assign flag_sw = wr_ctrl ? writedata[7] : ctrl_r.shutdown_event_flag;
   assign flag_auto_clr = restart_en & ~trip & ~wr_ctrl
      & ctrl_r.shutdown_event_flag;
   assign flag_nxt = trip | (flag_sw & ~flag_auto_clr);

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
         ctrl_nxt = pas_pkg::pas_ctrl_s'(writedata[7:0]);
      ctrl_nxt.shutdown_event_flag = flag_nxt;
   end

   // ****************************************************************
   // interrupt status, write one to clear, set beats clear
   // ****************************************************************
   wire [pas_pkg::IRQ_W-1:0] ev;

   assign ev[pas_pkg::IRQ_TRIP_BIT] = flag_nxt
      & ~ctrl_r.shutdown_event_flag;
   assign ev[pas_pkg::IRQ_RESTART_BIT] = flag_auto_clr;
   assign stat_nxt = ev | (stat_r & ~(wr_stat ?
      writedata[pas_pkg::IRQ_W-1:0] : {pas_pkg::IRQ_W{1'b0}}));
   assign irq = |(stat_r & mask_r);

   // register file update
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ctrl_r <= pas_pkg::pas_ctrl_s'(pas_pkg::CTRL_RESET);
         cfg_r <= pas_pkg::CFG_RESET;
         stat_r <= pas_pkg::IRQ_RESET;
         mask_r <= pas_pkg::IRQ_RESET;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         if (wr_cfg)
            cfg_r <= writedata[1:0];
         if (wr_mask)
            mask_r <= writedata[pas_pkg::IRQ_W-1:0];
      end
   end

   // ****************************************************************
   // output pins, registered, one generate lane per pin
   // ****************************************************************
   wire [pas_pkg::PIN_N-1:0] drv_all;
   wire [pas_pkg::PIN_N-1:0] oen_all;
   genvar gi;
   generate
      for (gi = 0; gi < pas_pkg::PIN_N; gi++)
      begin : g_pin
         wire [1:0] pstate;
         // A and C share one field, B and D the other
         assign pstate = (gi == pas_pkg::PIN_A || gi == pas_pkg::PIN_C) ?
            ctrl_r.pair_ac_shutdown_state :
            ctrl_r.pair_bd_shutdown_state;
         assign drv_all[gi] = ctrl_r.shutdown_event_flag ?
            (pstate == pas_pkg::PS_HIGH) : pwm_in[gi];
         assign oen_all[gi] = ctrl_r.shutdown_event_flag
            & pstate[pas_pkg::PS_TRI_BIT];
      end
   endgenerate

   // one process owns the pin vectors, so no bit has two writers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pwm_out <= 4'h0;
         pwm_oe_n <= 4'h0;
      end
      else
      begin
         pwm_out <= drv_all;
         pwm_oe_n <= oen_all;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   wire flag = ctrl_r.shutdown_event_flag;

   property p_trip_sets;
      @(posedge core_clk) disable iff (rst)
      trip |=> ctrl_r.shutdown_event_flag;
   endproperty
   a_trip_sets: assert property (p_trip_sets)
      else $error("trip did not set shutdown flag");

   property p_normal_pass;
      @(posedge core_clk) disable iff (rst)
      !flag |=> pwm_out == $past(pwm_in) && pwm_oe_n == 4'h0;
   endproperty
   a_normal_pass: assert property (p_normal_pass)
      else $error("outputs not following pwm when flag clear");

   property p_disabled;
      @(posedge core_clk) disable iff (rst)
      ctrl_r.shutdown_source_select == pas_pkg::SRC_OFF && !flag
      && !wr_ctrl |=> !ctrl_r.shutdown_event_flag;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("flag set with shutdown disabled");

   property p_cmp_one;
      @(posedge core_clk) disable iff (rst)
      ctrl_r.shutdown_source_select == pas_pkg::SRC_CMP_ONE
      && cmp_one_eff |=> ctrl_r.shutdown_event_flag;
   endproperty
   a_cmp_one: assert property (p_cmp_one)
      else $error("comparator one did not trip");

   property p_int_low;
      @(posedge core_clk) disable iff (rst)
      ctrl_r.shutdown_source_select == pas_pkg::SRC_INT && !int_pin
      |=> ctrl_r.shutdown_event_flag;
   endproperty
   a_int_low: assert property (p_int_low)
      else $error("low interrupt pin did not set flag");

   property p_int_any;
      @(posedge core_clk) disable iff (rst)
      ctrl_r.shutdown_source_select == pas_pkg::SRC_INT_ANY
      && (cmp_one_eff || cmp_two_eff) |=> ctrl_r.shutdown_event_flag;
   endproperty
   a_int_any: assert property (p_int_any)
      else $error("comparator under combined select did not trip");

   property p_ac_low;
      @(posedge core_clk) disable iff (rst)
      flag && ctrl_r.pair_ac_shutdown_state == pas_pkg::PS_LOW |=>
      !pwm_out[pas_pkg::PIN_A] && !pwm_out[pas_pkg::PIN_C]
      && !pwm_oe_n[pas_pkg::PIN_A] && !pwm_oe_n[pas_pkg::PIN_C];
   endproperty
   a_ac_low: assert property (p_ac_low)
      else $error("pair A/C not driven low in shutdown");

   property p_ac_tri;
      @(posedge core_clk) disable iff (rst)
      flag && ctrl_r.pair_ac_shutdown_state[pas_pkg::PS_TRI_BIT] |=>
      pwm_oe_n[pas_pkg::PIN_A] && pwm_oe_n[pas_pkg::PIN_C];
   endproperty
   a_ac_tri: assert property (p_ac_tri)
      else $error("pair A/C not released in shutdown");

   property p_bd_high;
      @(posedge core_clk) disable iff (rst)
      flag && ctrl_r.pair_bd_shutdown_state == pas_pkg::PS_HIGH |=>
      pwm_out[pas_pkg::PIN_B] && pwm_out[pas_pkg::PIN_D]
      && !pwm_oe_n[pas_pkg::PIN_B] && !pwm_oe_n[pas_pkg::PIN_D];
   endproperty
   a_bd_high: assert property (p_bd_high)
      else $error("pair B/D not driven high in shutdown");

   property p_restart;
      @(posedge core_clk) disable iff (rst)
      flag && restart_en && !trip && !wr_ctrl
      |=> !ctrl_r.shutdown_event_flag ##0 stat_r[pas_pkg::IRQ_RESTART_BIT];
   endproperty
   a_restart: assert property (p_restart)
      else $error("auto restart did not clear flag");

   property p_sticky;
      @(posedge core_clk) disable iff (rst)
      flag && !restart_en && !wr_ctrl |=> ctrl_r.shutdown_event_flag;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag cleared without software");

   property p_sync_hold;
      @(posedge core_clk) disable iff (rst)
      sync_en && !timer_one_tick ##1 sync_en |-> $stable(cmp_one_eff);
   endproperty
   a_sync_hold: assert property (p_sync_hold)
      else $error("synced comparator moved without timer tick");

endmodule

/* sim/pas_far_model.sv */
// far-side model: comparators, interrupt pin, timer tick and pwm pins
`timescale 1ns/100ps
module pas_far_model
(
   input wire logic core_clk,
   input wire logic cmp_one_req,
   input wire logic cmp_two_req,
   input wire logic int_low_req,
   input wire logic tick_req,
   input wire logic [3:0] pwm_req,
   output logic comparator_one,
   output logic comparator_two,
   output logic int_pin,
   output logic timer_one_tick,
   output logic [3:0] pwm_in,
   input wire logic [3:0] pwm_out,
   input wire logic [3:0] pwm_oe_n,
   output logic [3:0] pin_level
);
   // ****************************************************************
   // source and pin behaviour
   // ****************************************************************
   logic [3:0] last_r;

   // idle levels: comparators low, interrupt pin pulled high
   initial
   begin
      comparator_one = 1'b0;
      comparator_two = 1'b0;
      int_pin = 1'b1;
      timer_one_tick = 1'b0;
      pwm_in = 4'h0;
      last_r = 4'h0;
   end

   // sources move just after an edge, one cycle behind the request
   always @(posedge core_clk)
   begin
      comparator_one <= cmp_one_req;
      comparator_two <= cmp_two_req;
      int_pin <= ~int_low_req; // low level is the trip source
      timer_one_tick <= tick_req;
      pwm_in <= pwm_req;
      last_r <= pin_level;
   end

   // released pins have no pull, so they wander instead of holding
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         pin_level[i] = pwm_oe_n[i] ? ~last_r[i] : pwm_out[i];
   end
endmodule

/* sim/tb.sv */
// self-checking bench for the auto-shutdown control block
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
   // ****************************************************************
   // signals, clock and instances
   // ****************************************************************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, irq, comparator_one, comparator_two, int_pin;
   logic timer_one_tick;
   logic [3:0] pwm_in, pwm_out, pwm_oe_n, pin_level;
   logic c1_req = 1'b0, c2_req = 1'b0, int_req = 1'b0, tick_req = 1'b0;
   logic [3:0] pwm_req = 4'ha;
   logic [31:0] rd;
   logic [3:0] exp_out, exp_oe;
   int bad_count = 0;
   int total_checks = 0;

   // free-running 25 MHz clock
   initial
   begin
      forever #20 core_clk = ~core_clk;
   end

   pas_shutdown_ctrl i_dut (.core_clk(core_clk), .rst(rst),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq),
      .comparator_one(comparator_one), .comparator_two(comparator_two),
      .int_pin(int_pin), .timer_one_tick(timer_one_tick),
      .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n));

   pas_far_model i_far (.core_clk(core_clk), .cmp_one_req(c1_req),
      .cmp_two_req(c2_req), .int_low_req(int_req), .tick_req(tick_req),
      .pwm_req(pwm_req), .comparator_one(comparator_one),
      .comparator_two(comparator_two), .int_pin(int_pin),
      .timer_one_tick(timer_one_tick), .pwm_in(pwm_in), .pwm_out(pwm_out),
      .pwm_oe_n(pwm_oe_n), .pin_level(pin_level));

   // ****************************************************************
   // bus tasks and verdict
   // ****************************************************************
   // one avalon access; only the watchdog bounds the wait
   task automatic av_xfer(input logic wr, input logic [3:0] a,
      input logic [7:0] d);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= 4'hf;
      write <= wr;
      read <= ~wr;
      do
      begin
         @(posedge core_clk);
      end
      while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge core_clk); // edge gap so strobes are not driven twice
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // watchdog, far beyond the roughly 450 cycles the tests take
   initial
   begin
      #400000;
      bad_count++;
      wrap_up();
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial
   begin
      settle(3);
      rst <= 1'b0;
      settle(1);
      // reset values and an unmapped read
      av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
      `CHK(rd, 32'h0)
      av_xfer(1'b0, 4'h1, 8'h00);
      `CHK(rd, 32'h0)
      `CHK(pwm_oe_n, 4'h0)
      // every select code against each single source; flag is sticky
      for (int code = 0; code < 8; code++)
      begin
         for (int s = 0; s < 3; s++)
         begin
            av_xfer(1'b1, pas_pkg::OFF_CTRL, {1'b0, code[2:0], 4'h0});
            c1_req <= (s == 0);
            c2_req <= (s == 1);
            int_req <= (s == 2);
            settle(3);
            c1_req <= 1'b0;
            c2_req <= 1'b0;
            int_req <= 1'b0;
            settle(3);
            av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
            `CHK(rd[7], code[s])
            av_xfer(1'b1, pas_pkg::OFF_CTRL, 8'h00);
         end
      end
      // every pin state of both pairs, flag forced by software
      for (int s = 0; s < 4; s++)
      begin
         av_xfer(1'b1, pas_pkg::OFF_CTRL, {4'h8, s[1:0], 2'(3 - s)});
         settle(2);
         exp_out = {2'(3 - s) == 2'h1, s[1:0] == 2'h1,
            2'(3 - s) == 2'h1, s[1:0] == 2'h1};
         exp_oe = {(3 - s) > 1, s > 1, (3 - s) > 1, s > 1};
         `CHK(pwm_out, exp_out)
         `CHK(pwm_oe_n, exp_oe)
         `CHK(pin_level & ~exp_oe, exp_out & ~exp_oe)
      end
      av_xfer(1'b1, pas_pkg::OFF_CTRL, 8'h00);
      settle(2);
      `CHK(pwm_out, pwm_req)
      `CHK(pwm_oe_n, 4'h0)
      // automatic restart on the interrupt pin, with status and mask
      av_xfer(1'b1, pas_pkg::OFF_STAT, 8'h03);
      av_xfer(1'b1, pas_pkg::OFF_CFG, 8'h01);
      av_xfer(1'b1, pas_pkg::OFF_CTRL, 8'h44);
      int_req <= 1'b1;
      settle(4);
      `CHK(pwm_out, 4'h5)
      av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
      `CHK(rd[7], 1'b1)
      int_req <= 1'b0;
      settle(4);
      `CHK(pwm_out, pwm_req)
      av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
      `CHK(rd[7:0], 8'h44)
      av_xfer(1'b0, pas_pkg::OFF_STAT, 8'h00);
      `CHK(rd[1:0], 2'h3)
      `CHK(irq, 1'b0)
      av_xfer(1'b1, pas_pkg::OFF_MASK, 8'h02);
      `CHK(irq, 1'b1)
      av_xfer(1'b1, pas_pkg::OFF_STAT, 8'h03);
      `CHK(irq, 1'b0)
      // synced comparator waits for the timer tick
      av_xfer(1'b1, pas_pkg::OFF_CFG, 8'h02);
      av_xfer(1'b1, pas_pkg::OFF_CTRL, 8'h10);
      c1_req <= 1'b1;
      settle(5);
      av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
      `CHK(rd[7], 1'b0)
      tick_req <= 1'b1;
      settle(1);
      tick_req <= 1'b0;
      settle(4);
      av_xfer(1'b0, pas_pkg::OFF_CTRL, 8'h00);
      `CHK(rd[7], 1'b1)
      c1_req <= 1'b0;
      wrap_up();
   end
endmodule
